// File: bench/test_rcf_reset_cause.sv
// Purpose: Self-checking bench for the reset-cause flag block
// Assumes: One bus access at a time; clk_en high except in the freeze test
// Notes:   Async sources get four edges to cross the synchronisers
`timescale 1ns/1ps
`default_nettype none
module test_rcf_reset_cause
  import rcf_pkg::*;
;
  // ----------------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------------
  logic        sys_clk;
  logic        rst_n;
  logic        clk_en;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  evt;
  logic        master_clear_pin_n;
  logic        power_on_req;
  logic        brownout_req;
  logic [7:0]  reset_cause_flags;
  logic        irq;
  logic [31:0] rd;
  int          n_fail;
  int          tests_run;

  rcf_reset_cause dut_u (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .clk_en              (clk_en),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .stack_overflow_evt  (evt[0]),
    .stack_underflow_evt (evt[1]),
    .reset_instr_evt     (evt[2]),
    .master_clear_pin_n  (master_clear_pin_n),
    .power_on_req        (power_on_req),
    .brownout_req        (brownout_req),
    .reset_cause_flags   (reset_cause_flags),
    .irq                 (irq)
  );

  always #2 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Extra edge after release keeps two requests out of one time step
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    logic ok;
    ok = 1'b0;
    avs_address    <= a;
    avs_writedata  <= 32'(d);
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge sys_clk);
      ok = (avs_waitrequest === 1'b0);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
    if (!ok) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    check(rd, 32'(exp));
  endtask

  task automatic pulse(input logic [2:0] m);
    evt <= m;
    @(posedge sys_clk);
    evt <= 3'h0;
    @(posedge sys_clk);
  endtask

  task automatic settle();
    repeat (4) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_vals();
    check(reset_cause_flags, 8'h0C);
    rdc(RCF_OFS_FLAGS, 8'h0C);
    rdc(RCF_OFS_IRQ_STAT, 8'h00);
    rdc(RCF_OFS_IRQ_EN, 8'h00);
    rdc(RCF_OFS_IRQ_CLR, 8'h00);
    $display("done: reset values");
  endtask

  task automatic t_sw_access();
    wr(RCF_OFS_FLAGS, 8'hFF);
    rdc(RCF_OFS_FLAGS, 8'hCF);
    bus(1'b1, RCF_OFS_FLAGS, 8'h00, 4'h0);
    check(reset_cause_flags, 8'hCF);
    wr(RCF_OFS_FLAGS, 8'h00);
    check(reset_cause_flags, 8'h00);
    wr(RCF_OFS_FLAGS, 8'h0F);
    check(reset_cause_flags, 8'h0F);
    $display("done: software access");
  endtask

  task automatic t_events();
    pulse(3'b001);
    check(reset_cause_flags, 8'h8F);
    pulse(3'b010);
    check(reset_cause_flags, 8'hCF);
    pulse(3'b100);
    check(reset_cause_flags, 8'hCB);
    wr(RCF_OFS_FLAGS, 8'h0F);
    pulse(3'b111);
    check(reset_cause_flags, 8'hCB);
    $display("done: sync events");
  endtask

  task automatic t_async();
    wr(RCF_OFS_FLAGS, 8'h0F);
    master_clear_pin_n <= 1'b0;
    settle();
    check(reset_cause_flags, 8'h07);
    master_clear_pin_n <= 1'b1;
    settle();
    check(reset_cause_flags, 8'h07);
    pulse(3'b001);
    brownout_req <= 1'b1;
    settle();
    check(reset_cause_flags, 8'h0E);
    brownout_req <= 1'b0;
    settle();
    wr(RCF_OFS_FLAGS, 8'h0F);
    power_on_req <= 1'b1;
    settle();
    check(reset_cause_flags, 8'h0C);
    power_on_req <= 1'b0;
    settle();
    $display("done: async sources");
  endtask

  task automatic t_irq();
    wr(RCF_OFS_IRQ_CLR, 8'hFF);
    wr(RCF_OFS_IRQ_EN, 8'hFF);
    rdc(RCF_OFS_IRQ_EN, 8'hCF);
    wr(RCF_OFS_IRQ_EN, 8'h80);
    rdc(RCF_OFS_IRQ_STAT, 8'h00);
    check(irq, 1'b0);
    pulse(3'b010);
    check(irq, 1'b0);
    rdc(RCF_OFS_IRQ_STAT, 8'h40);
    pulse(3'b001);
    check(irq, 1'b1);
    rdc(RCF_OFS_IRQ_STAT, 8'hC0);
    wr(RCF_OFS_IRQ_CLR, 8'h80);
    check(irq, 1'b0);
    rdc(RCF_OFS_IRQ_STAT, 8'h40);
    $display("done: interrupt");
  endtask

  // Events while frozen are lost, so nothing may move
  task automatic t_freeze();
    clk_en <= 1'b0;
    pulse(3'b101);
    check(reset_cause_flags, 8'hCC);
    clk_en <= 1'b1;
    rdc(RCF_OFS_IRQ_STAT, 8'h40);
    $display("done: clock enable");
  endtask

  task automatic t_rereset();
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check(reset_cause_flags, 8'h0C);
    check(irq, 1'b0);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(RCF_OFS_IRQ_EN, 8'h00);
    $display("done: second reset");
  endtask

  initial begin
    sys_clk            = 1'b0;
    rst_n              = 1'b0;
    clk_en             = 1'b1;
    avs_address        = 4'h0;
    avs_read           = 1'b0;
    avs_write          = 1'b0;
    avs_writedata      = 32'h0000_0000;
    avs_byteenable     = 4'h0;
    evt                = 3'h0;
    master_clear_pin_n = 1'b1;
    power_on_req       = 1'b0;
    brownout_req       = 1'b0;
    n_fail             = 0;
    tests_run          = 0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    t_reset_vals();
    t_sw_access();
    t_events();
    t_async();
    t_irq();
    t_freeze();
    t_rereset();
    stop_test();
  end
endmodule
`default_nettype wire

// File: rtl/rcf_pkg.sv
// Purpose: Shared constants and types for the reset-cause flag block
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one word per register
// Notes:   Flag layout is reused by the interrupt status and enable registers
package rcf_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] RCF_OFS_FLAGS    = 4'h0;
  localparam logic [3:0] RCF_OFS_IRQ_STAT = 4'h4;
  localparam logic [3:0] RCF_OFS_IRQ_CLR  = 4'h8;
  localparam logic [3:0] RCF_OFS_IRQ_EN   = 4'hC;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int RCF_BIT_OVF   = 7;
  localparam int RCF_BIT_UNF   = 6;
  localparam int RCF_BIT_PIN   = 3;
  localparam int RCF_BIT_INSTR = 2;
  localparam int RCF_BIT_POR   = 1;
  localparam int RCF_BIT_BOR   = 0;

  localparam logic [7:0] RCF_FLAGS_RST  = 8'h0C;
  localparam logic [7:0] RCF_IMPL_MASK  = 8'hCF;
  localparam logic [7:0] RCF_IRQ_RST    = 8'h00;
  localparam logic [7:0] RCF_RDATA_RST  = 8'h00;
  localparam int         RCF_NUM_ASYNC  = 3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [RCF_NUM_ASYNC-1:0] s1;
    logic [RCF_NUM_ASYNC-1:0] s2;
  } rcf_sync_state_t;

  typedef struct packed {
    logic [7:0]               flags;
    logic [7:0]               irq_stat;
    logic [7:0]               irq_en;
    logic [7:0]               rdata;
    logic                     waitreq;
    logic                     irq;
    logic [RCF_NUM_ASYNC-1:0] async_prev;
  } rcf_state_t;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } rcf_bus_req_t;

endpackage

// File: rtl/rcf_reset_cause.sv
// Purpose: Reset-cause flag register with Avalon-MM access and interrupt
// Assumes: Stack and reset-instruction events are one-cycle sys_clk pulses;
//          power-on, brown-out and pin levels are asynchronous
// Notes:   rst_n stands for the power-on state of the flags
// Notes on behaviour
// - Stack overflow sets the top flag; power-on or brown-out clear it.
// - Stack underflow sets its flag; power-on or brown-out clear it.
// - A master-clear pin reset drives its flag low; it reads 1 at power-on.
// - A reset instruction clears its flag; it reads 1 at power-on.
// - Power-on clears its flag, other resets leave it; software sets it.
// - Brown-out or power-on clears the brown-out flag; software sets it.
// - The two unused bits ignore writes and read zero.
// - Each flag moves only by its own event, a power-on or brown-out, or a direct software write.
// - Every reset source keeps a flag of its own.
`timescale 1ns/1ps
`default_nettype none
module rcf_reset_cause
  import rcf_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Reset sources
  input  wire logic        stack_overflow_evt,
  input  wire logic        stack_underflow_evt,
  input  wire logic        reset_instr_evt,
  input  wire logic        master_clear_pin_n,
  input  wire logic        power_on_req,
  input  wire logic        brownout_req,
  // Flags and interrupt
  output logic [7:0]       reset_cause_flags,
  output logic             irq
);

  rcf_state_t               st_reg;
  rcf_state_t               st_next;
  rcf_bus_req_t             req;
  logic [RCF_NUM_ASYNC-1:0] async_sync;
  logic [7:0]               evt;
  logic                     pin_evt;
  logic                     por_evt;
  logic                     bor_evt;
  logic                     bus_ack;
  logic                     wr_commit;

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  // Lane 0 carries the inverted pin so that all lanes idle low
  rcf_sync2 u_sync (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .async_in  ({brownout_req, power_on_req, ~master_clear_pin_n}),
    .rst_level (3'h0),
    .sync_out  (async_sync)
  );

  // ----------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------
  assign req = '{address:    avs_address,
                 read:       avs_read,
                 write:      avs_write,
                 writedata:  avs_writedata,
                 byteenable: avs_byteenable};

  // Rising edges only, so a held reset level counts once
  assign pin_evt = async_sync[0] & ~st_reg.async_prev[0];
  assign por_evt = async_sync[1] & ~st_reg.async_prev[1];
  assign bor_evt = async_sync[2] & ~st_reg.async_prev[2];

  // One event bit per flag position
  always_comb begin
    evt                = 8'h00;
    evt[RCF_BIT_OVF]   = stack_overflow_evt;
    evt[RCF_BIT_UNF]   = stack_underflow_evt;
    evt[RCF_BIT_PIN]   = pin_evt;
    evt[RCF_BIT_INSTR] = reset_instr_evt;
    evt[RCF_BIT_POR]   = por_evt;
    evt[RCF_BIT_BOR]   = bor_evt;
  end

  // Request was sampled last edge; answer now with waitrequest low
  assign bus_ack   = (req.read | req.write) & ~st_reg.waitreq;
  assign wr_commit = bus_ack & req.write & req.byteenable[0];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.async_prev = async_sync;

      // Bus handshake: one wait cycle, then one answer cycle
      st_next.waitreq = ~((req.read | req.write) & st_reg.waitreq);
      if ((req.read | req.write) & st_reg.waitreq) begin
        case (req.address[3:2])
          RCF_OFS_FLAGS[3:2]:    st_next.rdata = st_reg.flags;
          RCF_OFS_IRQ_STAT[3:2]: st_next.rdata = st_reg.irq_stat;
          RCF_OFS_IRQ_EN[3:2]:   st_next.rdata = st_reg.irq_en;
          default:               st_next.rdata = RCF_RDATA_RST;
        endcase
      end

      // Software writes first, so hardware events win below
      if (wr_commit) begin
        case (req.address[3:2])
          RCF_OFS_FLAGS[3:2]:
            st_next.flags = req.writedata[7:0] & RCF_IMPL_MASK;
          RCF_OFS_IRQ_CLR[3:2]:
            st_next.irq_stat = st_reg.irq_stat & ~req.writedata[7:0];
          RCF_OFS_IRQ_EN[3:2]:
            st_next.irq_en = req.writedata[7:0] & RCF_IMPL_MASK;
          default: ;
        endcase
      end

      // Power-on or brown-out restores the power-up view of the others
      if (por_evt | bor_evt) begin
        st_next.flags[RCF_BIT_OVF]   = 1'b0;
        st_next.flags[RCF_BIT_UNF]   = 1'b0;
        st_next.flags[RCF_BIT_PIN]   = 1'b1;
        st_next.flags[RCF_BIT_INSTR] = 1'b1;
        st_next.flags[RCF_BIT_BOR]   = 1'b0;
      end
      if (por_evt) begin
        st_next.flags[RCF_BIT_POR] = 1'b0;
      end
      // Each cause touches only its own flag
      if (stack_overflow_evt) begin
        st_next.flags[RCF_BIT_OVF] = 1'b1;
      end
      if (stack_underflow_evt) begin
        st_next.flags[RCF_BIT_UNF] = 1'b1;
      end
      if (pin_evt) begin
        st_next.flags[RCF_BIT_PIN] = 1'b0;
      end
      if (reset_instr_evt) begin
        st_next.flags[RCF_BIT_INSTR] = 1'b0;
      end

      // Set wins over a clear landing in the same cycle
      st_next.irq_stat = st_next.irq_stat | evt;
      st_next.irq      = |(st_next.irq_stat & st_next.irq_en);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.flags      <= RCF_FLAGS_RST;
      st_reg.irq_stat   <= RCF_IRQ_RST;
      st_reg.irq_en     <= RCF_IRQ_RST;
      st_reg.rdata      <= RCF_RDATA_RST;
      st_reg.waitreq    <= 1'b1;
      st_reg.irq        <= 1'b0;
      st_reg.async_prev <= 3'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata      = {24'h00_0000, st_reg.rdata};
  assign avs_waitrequest   = st_reg.waitreq;
  assign reset_cause_flags = st_reg.flags;
  assign irq               = st_reg.irq;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  chk_ovf_set: assert property (
    clk_en && stack_overflow_evt |=> reset_cause_flags[RCF_BIT_OVF])
    else $error("overflow flag not set");

  chk_unf_set: assert property (
    clk_en && stack_underflow_evt |=> reset_cause_flags[RCF_BIT_UNF])
    else $error("underflow flag not set");

  chk_pin_clear: assert property (
    clk_en && $rose(async_sync[0]) |=> !reset_cause_flags[RCF_BIT_PIN])
    else $error("pin reset flag not cleared");

  chk_instr_clear: assert property (
    clk_en && reset_instr_evt |=> !reset_cause_flags[RCF_BIT_INSTR])
    else $error("reset instruction flag not cleared");

  chk_por_clear: assert property (
    clk_en && por_evt |=> reset_cause_flags[1:0] == 2'b00)
    else $error("power-on did not clear status bits");

  chk_bor_keeps_por: assert property (
    clk_en && bor_evt && !por_evt && !wr_commit
      |=> $stable(reset_cause_flags[RCF_BIT_POR]))
    else $error("brown-out changed power-on bit");

  chk_bor_clear: assert property (
    clk_en && bor_evt |=> !reset_cause_flags[RCF_BIT_BOR])
    else $error("brown-out bit not cleared");

  chk_unused_zero: assert property (
    !avs_waitrequest && avs_read && avs_address == RCF_OFS_FLAGS
      |-> avs_readdata[5:4] == 2'b00 && reset_cause_flags[5:4] == 2'b00)
    else $error("unused bits read nonzero");

  chk_flags_hold: assert property (
    (!clk_en || (evt == 8'h00 && !wr_commit)) |=> $stable(reset_cause_flags))
    else $error("flags moved without cause");

  chk_indep_ovf: assert property (
    clk_en && stack_overflow_evt && evt[3:0] == 4'h0 && !wr_commit
      |=> reset_cause_flags[3:0] == $past(reset_cause_flags[3:0]))
    else $error("overflow disturbed other flags");

  chk_bus_answer: assert property (
    clk_en && (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle");

  chk_irq_level: assert property (
    clk_en |=> irq == |(st_reg.irq_stat & st_reg.irq_en))
    else $error("irq does not follow status");

  // ----------------------------------------------------------------------
  // Flag movement: every edge of a flag needs its own cause
  // ----------------------------------------------------------------------
  chk_pin_no_rise: assert property (
    clk_en && !wr_commit && !por_evt && !bor_evt
      |=> !$rose(reset_cause_flags[RCF_BIT_PIN]))
    else $error("pin reset flag set without cause");

  chk_instr_no_rise: assert property (
    clk_en && !wr_commit && !por_evt && !bor_evt
      |=> !$rose(reset_cause_flags[RCF_BIT_INSTR]))
    else $error("instruction flag set without cause");

  chk_ovf_no_fall: assert property (
    clk_en && !wr_commit && !por_evt && !bor_evt
      |=> !$fell(reset_cause_flags[RCF_BIT_OVF]))
    else $error("overflow flag cleared without cause");

  chk_unf_no_fall: assert property (
    clk_en && !wr_commit && !por_evt && !bor_evt
      |=> !$fell(reset_cause_flags[RCF_BIT_UNF]))
    else $error("underflow flag cleared without cause");

  chk_por_no_rise: assert property (
    clk_en && !wr_commit |=> !$rose(reset_cause_flags[RCF_BIT_POR]))
    else $error("power-on bit set by hardware");

  chk_bor_no_rise: assert property (
    clk_en && !wr_commit |=> !$rose(reset_cause_flags[RCF_BIT_BOR]))
    else $error("brown-out bit set by hardware");

  chk_por_no_fall: assert property (
    clk_en && !por_evt && !wr_commit
      |=> !$fell(reset_cause_flags[RCF_BIT_POR]))
    else $error("power-on bit cleared without cause");

  chk_bor_no_fall: assert property (
    clk_en && !por_evt && !bor_evt && !wr_commit
      |=> !$fell(reset_cause_flags[RCF_BIT_BOR]))
    else $error("brown-out bit cleared without cause");

  chk_sw_flags: assert property (
    clk_en && wr_commit && evt == 8'h00
      && avs_address[3:2] == RCF_OFS_FLAGS[3:2]
      |=> reset_cause_flags == ($past(avs_writedata[7:0]) & RCF_IMPL_MASK))
    else $error("software write did not land");

  chk_unused_flags: assert property (
    reset_cause_flags[5:4] == 2'b00)
    else $error("unused flag bits set");

  chk_read_flags: assert property (
    clk_en && avs_read && avs_waitrequest
      && avs_address[3:2] == RCF_OFS_FLAGS[3:2]
      |=> avs_readdata[7:0] == $past(reset_cause_flags))
    else $error("flag read data wrong");

  chk_bus_idle: assert property (
    clk_en && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");

  chk_stat_set: assert property (
    clk_en && stack_overflow_evt |=> st_reg.irq_stat[RCF_BIT_OVF])
    else $error("status set lost to a clear");

  cov_overflow: cover property (clk_en && stack_overflow_evt);
  cov_por_pin:  cover property (clk_en && por_evt && pin_evt);
  cov_sw_write: cover property (wr_commit && avs_address == RCF_OFS_FLAGS);
  cov_irq:      cover property ($rose(irq));
  cov_freeze:   cover property (!clk_en && stack_overflow_evt);

endmodule
`default_nettype wire

// File: rtl/rcf_sync2.sv
// Purpose: Two-flop synchronisers for the asynchronous reset-source levels
// Assumes: Inputs are levels that stay put for several clocks
// Notes:   Only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none
module rcf_sync2
  import rcf_pkg::*;
(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  // Levels
  input  wire logic [RCF_NUM_ASYNC-1:0] async_in,
  input  wire logic [RCF_NUM_ASYNC-1:0] rst_level,
  output logic      [RCF_NUM_ASYNC-1:0] sync_out
);

  rcf_sync_state_t st_reg;
  rcf_sync_state_t st_next;

  // ----------------------------------------------------------------------
  // Stage shift, one lane per input
  // ----------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    if (clk_en) begin
      st_next.s1 = async_in;
      st_next.s2 = st_reg.s1;
    end
  end

  // One register process keeps a single driver on the stage struct
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Idle level of each lane after reset is a tie-off from the parent
  genvar gi;
  generate
    for (gi = 0; gi < RCF_NUM_ASYNC; gi++) begin : g_lane
      assign sync_out[gi] = st_reg.s2[gi] ^ rst_level[gi];
    end
  endgenerate

endmodule
`default_nettype wire
